// ### drive_error_history_map.svh
// Functional notes
// RL1: Keep last stop cause, ten history entries.
// RL2: Async error: stop state, status, cause.
// RL3: Flag failed or invalid parameter commands.
// RL4: LED flashes booting, lit ready, 2/3 codes.
// RL5: LED codes four, five and six flashes.
// RL6: Last stop cause reads zero without error.
// RL7: Log error; follow-on errors not recorded.
// RL8: History survives power loss.
// RL9: Write one clears; zero readback means done.
// RL10: Rewind write moves pointer to oldest.
// RL11: Sequential reads; pointer advances per entry.
// RL12: Empty slot reads error code zero.
// RL13: Oldest first; tenth slot holds newest.
// RL14: Code read latches entry, advances pointer.
// RL15: Severity codes zero to four as listed.
// RL16: Class four survives error reset.
// RL17: Code and severity are 16-bit words.
// RL18: Latched entry gives time and qualifier.
// RL19: Full history drops oldest, shifts, appends.
`ifndef DRIVE_ERROR_HISTORY_MAP_SVH
`define DRIVE_ERROR_HISTORY_MAP_SVH
`define HIST_DEPTH 10
`define ADDR_HISTORY_CLEAR 16'h3b08
`define ADDR_POINTER_REWIND 16'h3b0a
`define ADDR_ERROR_CODE 16'h3c02
`define ADDR_ERROR_SEVERITY 16'h3c04
`define ADDR_ERROR_TIME_HI 16'h3c06
`define ADDR_ERROR_TIME_LO 16'h3c07
`define ADDR_ERROR_QUAL 16'h3c08
`define ADDR_LAST_STOP 16'h3c10
`define ADDR_COMM_STATUS 16'h3c12
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`define CS_ASYNC_BIT 0
`define CS_SYNC_BIT 1
`define CS_QSTOP_BIT 2
`define CS_FAULT_BIT 3
`define CS_SEV_LSB 4
`define CS_SEV_MSB 6
`define CLK_KHZ 20000
`define FLASH_MS 200
`define PAUSE_MS 1000
`define FLASH_CYC_DEF (32'(`FLASH_MS * `CLK_KHZ))
`define PAUSE_CYC_DEF (32'(`PAUSE_MS * `CLK_KHZ))
`endif

// ### drive_error_history_pkg.sv
`default_nettype none
package drive_error_history_pkg;
	// Encoding follows the class numbers 0..4 [RL15]
	typedef enum logic [2:0] {
		SEV_WARN,
		SEV_QSTOP7,
		SEV_QSTOP89,
		SEV_FATAL_ACK,
		SEV_FATAL_LOCK
	} severity_t;
	typedef enum logic [2:0] {
		NET_BOOT,
		NET_READY,
		NET_NOLINK,
		NET_BADIP,
		NET_DUPIP,
		NET_WAITADDR,
		NET_DEFIP
	} net_state_t;
	typedef enum logic [1:0] {OP_RUN, OP_QSTOP, OP_FAULT} op_state_t;
	typedef enum logic [1:0] {PH_ON, PH_OFF, PH_PAUSE} led_phase_t;
	typedef struct packed {
		logic [15:0] code;
		severity_t severity;
		logic [31:0] errTime;
		logic [15:0] qual;
	} entry_t;
endpackage
`default_nettype wire

// ### history_if.sv
`default_nettype none
interface history_if;
	import drive_error_history_pkg::*;
	logic wrEn;
	entry_t wrEntry;
	logic clr;
	logic [3:0] rdIdx;
	entry_t rdEntry;
	logic [3:0] count;
	modport store(input wrEn, wrEntry, clr, rdIdx, output rdEntry, count);
	modport ctrl(output wrEn, wrEntry, clr, rdIdx, input rdEntry, count);
endinterface
`default_nettype wire

// ### error_history_store.sv
`default_nettype none
`include "drive_error_history_map.svh"
module error_history_store
	import drive_error_history_pkg::*;
(
	input wire logic core_clk,
	input wire logic memInitn,
	history_if.store hist
);
	typedef struct packed {
		logic [3:0] count;
	} store_t;
	store_t state_ff;
	store_t nxt_state;
	entry_t mem [`HIST_DEPTH];
	logic full;

	assign full = (state_ff.count == 4'(`HIST_DEPTH));

	// Fill level; clear wins, a full store stays at ten
	always_comb begin
		nxt_state = state_ff;
		if (hist.clr) begin
			nxt_state.count = 4'h0; // [RL9]
		end else if (hist.wrEn && !full) begin
			nxt_state.count = state_ff.count + 4'h1;
		end
	end

	// Of the two resets only the factory init clears the level, not the warm reset
	always_ff @(posedge core_clk or negedge memInitn) begin
		if (!memInitn)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	// No reset on the array: contents outlive a warm reset [RL8]
	always_ff @(posedge core_clk) begin
		if (hist.wrEn && !hist.clr) begin
			if (full) begin
				for (int i = 0; i < `HIST_DEPTH - 1; i++) begin
					mem[i] <= mem[i + 1]; // [RL19]
				end
				mem[`HIST_DEPTH - 1] <= hist.wrEntry; // [RL13]
			end else begin
				mem[state_ff.count] <= hist.wrEntry; // [RL1] [RL13]
			end
		end
	end

	// Slots at or above the fill level read as all zero
	assign hist.rdEntry = (hist.rdIdx < state_ff.count) ?
		mem[hist.rdIdx] : '0; // [RL12]
	assign hist.count = state_ff.count;

	property p_count_max;
		@(posedge core_clk) disable iff (!memInitn)
		state_ff.count <= 4'(`HIST_DEPTH);
	endproperty
	a_count_max: assert property (p_count_max) // [RL1]
		else $error("history fill level above ten");

	property p_clear_empties;
		@(posedge core_clk) disable iff (!memInitn)
		hist.clr |=> (hist.count == 4'h0);
	endproperty
	a_clear_empties: assert property (p_clear_empties) // [RL9]
		else $error("history not empty after clear");
endmodule
`default_nettype wire

// ### run_led_flasher.sv
`default_nettype none
module run_led_flasher
	import drive_error_history_pkg::*;
#(
	parameter logic [31:0] FLASH_CYC = 32'h0000_0010,
	parameter logic [31:0] PAUSE_CYC = 32'h0000_0040
)(
	input wire logic core_clk,
	input wire logic resetn,
	input wire net_state_t netState,
	output logic runLed
);
	typedef struct packed {
		led_phase_t phase;
		logic [31:0] timer;
		logic [2:0] flashCnt;
		net_state_t seen;
		logic lit;
	} led_t;
	led_t state_ff;
	led_t nxt_state;
	logic [2:0] target;

	// Flashes per cycle; zero means flash without pause [RL4] [RL5]
	always_comb begin
		case (netState)
			NET_NOLINK: target = 3'h2;
			NET_BADIP: target = 3'h3;
			NET_DUPIP: target = 3'h4;
			NET_WAITADDR: target = 3'h5;
			NET_DEFIP: target = 3'h6;
			default: target = 3'h0;
		endcase
	end

	// Blink sequencer; a state change restarts from the pause
	always_comb begin
		nxt_state = state_ff;
		nxt_state.seen = netState;
		if (netState != state_ff.seen) begin
			nxt_state.phase = PH_PAUSE;
			nxt_state.timer = PAUSE_CYC - 32'h0000_0001;
			nxt_state.flashCnt = 3'h0;
		end else if (state_ff.timer != 32'h0000_0000) begin
			nxt_state.timer = state_ff.timer - 32'h0000_0001;
		end else begin
			case (state_ff.phase)
				PH_ON: begin
					nxt_state.phase = PH_OFF;
					nxt_state.timer = FLASH_CYC - 32'h0000_0001;
					nxt_state.flashCnt = state_ff.flashCnt + 3'h1;
				end
				PH_OFF: begin
					if (target != 3'h0 && state_ff.flashCnt >= target) begin
						nxt_state.phase = PH_PAUSE;
						nxt_state.timer = PAUSE_CYC - 32'h0000_0001;
					end else begin
						nxt_state.phase = PH_ON;
						nxt_state.timer = FLASH_CYC - 32'h0000_0001;
					end
				end
				PH_PAUSE: begin
					nxt_state.phase = PH_ON;
					nxt_state.timer = FLASH_CYC - 32'h0000_0001;
					nxt_state.flashCnt = 3'h0;
				end
				default: nxt_state.phase = PH_PAUSE;
			endcase
		end
		// Ready holds the LED steady regardless of phase [RL4]
		nxt_state.lit = (netState == NET_READY) ||
			(nxt_state.phase == PH_ON);
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign runLed = state_ff.lit;

	property p_ready_lit;
		@(posedge core_clk) disable iff (!resetn)
		(netState == NET_READY) |=> runLed;
	endproperty
	a_ready_lit: assert property (p_ready_lit) // [RL4]
		else $error("RUN LED dark while ready");

	c_pause_reached: cover property (@(posedge core_clk)
		disable iff (!resetn)
		state_ff.phase == PH_OFF ##1 state_ff.phase == PH_PAUSE);
endmodule
`default_nettype wire

// ### drive_error_history_log.sv
`default_nettype none
`include "drive_error_history_map.svh"
module drive_error_history_log
	import drive_error_history_pkg::*;
#(
	parameter logic [31:0] FLASH_CYC = `FLASH_CYC_DEF,
	parameter logic [31:0] PAUSE_CYC = `PAUSE_CYC_DEF
)(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic memInitn,
	input wire logic parReq,
	input wire logic parWr,
	input wire logic [15:0] parAddr,
	input wire logic [15:0] parWdata,
	input wire logic cmdReject,
	output logic parAck,
	output logic parErr,
	output logic [15:0] parRdata,
	input wire logic errEvent,
	input wire logic [15:0] errCode,
	input wire severity_t errSeverity,
	input wire logic [15:0] errQual,
	input wire logic [31:0] opHours,
	input wire logic errReset,
	input wire net_state_t netState,
	output logic runLed,
	output op_state_t opState,
	output logic [15:0] lastStopCause,
	output logic [15:0] commStatusWord
);
	typedef struct packed {
		logic [15:0] lastStop;
		severity_t lastSev;
		logic errActive;
		op_state_t opState;
		logic [3:0] rdPtr;
		entry_t hold;
		logic clrPending;
		logic [15:0] commStatus;
		logic ack;
		logic err;
		logic [15:0] rdata;
	} ctl_t;
	ctl_t state_ff;
	ctl_t nxt_state;
	logic logEn;
	logic clrEn;
	logic wrOk;

	history_if hist();

	error_history_store uStore (
		.core_clk(core_clk),
		.memInitn(memInitn),
		.hist(hist)
	);

	run_led_flasher #(
		.FLASH_CYC(FLASH_CYC),
		.PAUSE_CYC(PAUSE_CYC)
	) uLed (
		.core_clk(core_clk),
		.resetn(resetn),
		.netState(netState),
		.runLed(runLed)
	);

	// Store side of the history; entry stamped with operating hours
	assign hist.wrEn = logEn;
	assign hist.wrEntry = '{code: errCode, severity: errSeverity,
		errTime: opHours, qual: errQual};
	assign hist.clr = clrEn;
	assign hist.rdIdx = state_ff.rdPtr;

	// Control and parameter channel, one request per cycle at most
	always_comb begin
		nxt_state = state_ff;
		nxt_state.ack = 1'b0;
		nxt_state.err = 1'b0;
		logEn = 1'b0;
		clrEn = 1'b0;
		wrOk = (parWdata == `WORD_ONE) || (parWdata == `WORD_ZERO);

		// Error reset clears the stop unless the class is locked
		if (errReset && state_ff.errActive &&
			state_ff.lastSev != SEV_FATAL_LOCK) begin // [RL16]
			nxt_state.errActive = 1'b0;
			nxt_state.lastStop = `WORD_ZERO; // [RL6]
			nxt_state.opState = OP_RUN;
			nxt_state.commStatus[`CS_ASYNC_BIT] = 1'b0;
			nxt_state.commStatus[`CS_SYNC_BIT] = 1'b0;
			nxt_state.commStatus[`CS_QSTOP_BIT] = 1'b0;
			nxt_state.commStatus[`CS_FAULT_BIT] = 1'b0;
		end

		// Only the first error of a stop is logged; an event in the reset cycle of an active stop is dropped
		if (errEvent && !state_ff.errActive) begin
			logEn = 1'b1; // [RL7]
			if (errSeverity != SEV_WARN) begin
				nxt_state.errActive = 1'b1;
				nxt_state.lastStop = errCode; // [RL2]
				nxt_state.lastSev = errSeverity;
				nxt_state.commStatus[`CS_ASYNC_BIT] = 1'b1;
				nxt_state.commStatus[`CS_SEV_MSB:`CS_SEV_LSB] = errSeverity;
				if (errSeverity == SEV_FATAL_ACK ||
					errSeverity == SEV_FATAL_LOCK) begin
					nxt_state.opState = OP_FAULT; // [RL2]
					nxt_state.commStatus[`CS_FAULT_BIT] = 1'b1;
				end else begin
					nxt_state.opState = OP_QSTOP; // [RL2]
					nxt_state.commStatus[`CS_QSTOP_BIT] = 1'b1;
				end
			end
		end

		// Clear runs a cycle after the write; a logged error delays it
		if (state_ff.clrPending && !logEn) begin
			clrEn = 1'b1; // [RL9]
			nxt_state.clrPending = 1'b0;
			nxt_state.rdPtr = 4'h0;
		end

		if (parReq) begin
			nxt_state.ack = 1'b1;
			nxt_state.rdata = `WORD_ZERO;
			if (cmdReject) begin
				nxt_state.err = 1'b1; // [RL3]
			end else if (parWr) begin
				case (parAddr)
					`ADDR_HISTORY_CLEAR: begin
						if (!wrOk)
							nxt_state.err = 1'b1; // [RL3]
						else if (parWdata == `WORD_ONE)
							nxt_state.clrPending = 1'b1; // [RL9]
					end
					`ADDR_POINTER_REWIND: begin
						if (!wrOk)
							nxt_state.err = 1'b1; // [RL3]
						else if (parWdata == `WORD_ONE)
							nxt_state.rdPtr = 4'h0; // [RL10]
					end
					// Read-only or unknown parameter
					default: nxt_state.err = 1'b1; // [RL3]
				endcase
			end else begin
				case (parAddr)
					`ADDR_HISTORY_CLEAR:
						nxt_state.rdata = 16'(state_ff.clrPending); // [RL9]
					`ADDR_POINTER_REWIND:
						nxt_state.rdata = `WORD_ZERO;
					`ADDR_ERROR_CODE: begin
						// Latch the whole entry, then step on [RL14]
						nxt_state.hold = hist.rdEntry;
						nxt_state.rdata = hist.rdEntry.code; // [RL12] [RL17]
						if (state_ff.rdPtr < hist.count)
							nxt_state.rdPtr = state_ff.rdPtr + 4'h1; // [RL11]
					end
					`ADDR_ERROR_SEVERITY:
						nxt_state.rdata = 16'(state_ff.hold.severity); // [RL17]
					`ADDR_ERROR_TIME_HI:
						nxt_state.rdata = state_ff.hold.errTime[31:16]; // [RL18]
					`ADDR_ERROR_TIME_LO:
						nxt_state.rdata = state_ff.hold.errTime[15:0]; // [RL18]
					`ADDR_ERROR_QUAL:
						nxt_state.rdata = state_ff.hold.qual; // [RL18]
					`ADDR_LAST_STOP:
						nxt_state.rdata = state_ff.lastStop; // [RL6]
					`ADDR_COMM_STATUS:
						nxt_state.rdata = state_ff.commStatus;
					default: nxt_state.err = 1'b1; // [RL3]
				endcase
			end
			// Refused commands set the sync bit of the status word; an error reset that releases a stop clears it
			if (nxt_state.err)
				nxt_state.commStatus[`CS_SYNC_BIT] = 1'b1; // [RL3]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	// Answers and status come straight from the state flops
	assign parAck = state_ff.ack;
	assign parErr = state_ff.err;
	assign parRdata = state_ff.rdata;
	assign opState = state_ff.opState;
	assign lastStopCause = state_ff.lastStop;
	assign commStatusWord = state_ff.commStatus;

	property p_reject_flagged;
		@(posedge core_clk) disable iff (!resetn)
		parReq && cmdReject |=> parAck && parErr;
	endproperty
	a_reject_flagged: assert property (p_reject_flagged) // [RL3]
		else $error("rejected command not flagged");

	property p_stop_zero;
		@(posedge core_clk) disable iff (!resetn)
		!state_ff.errActive |-> lastStopCause == `WORD_ZERO;
	endproperty
	a_stop_zero: assert property (p_stop_zero) // [RL6]
		else $error("stop cause nonzero without error");

	property p_async_capture;
		@(posedge core_clk) disable iff (!resetn)
		errEvent && !state_ff.errActive && errSeverity != SEV_WARN
		|=> lastStopCause == $past(errCode) && opState != OP_RUN;
	endproperty
	a_async_capture: assert property (p_async_capture) // [RL2]
		else $error("error not captured as stop cause");

	property p_followon_ignored;
		@(posedge core_clk) disable iff (!resetn)
		state_ff.errActive && !errReset
		|=> $stable(lastStopCause) && !$past(logEn);
	endproperty
	a_followon_ignored: assert property (p_followon_ignored) // [RL7]
		else $error("follow-on error overwrote the cause");

	property p_lock_kept;
		@(posedge core_clk) disable iff (!resetn)
		state_ff.errActive && state_ff.lastSev == SEV_FATAL_LOCK
		|=> state_ff.errActive [*3];
	endproperty
	a_lock_kept: assert property (p_lock_kept) // [RL16]
		else $error("class four error cleared by reset");

	property p_clear_done;
		@(posedge core_clk) disable iff (!resetn)
		parReq && parWr && !cmdReject && parAddr == `ADDR_HISTORY_CLEAR
		&& parWdata == `WORD_ONE |=> state_ff.clrPending ##[1:4]
		(!state_ff.clrPending && hist.count == 4'h0);
	endproperty
	a_clear_done: assert property (p_clear_done) // [RL9]
		else $error("history clear did not finish");

	property p_rewind;
		@(posedge core_clk) disable iff (!resetn)
		parReq && parWr && !cmdReject && parAddr == `ADDR_POINTER_REWIND
		&& parWdata == `WORD_ONE |=> state_ff.rdPtr == 4'h0;
	endproperty
	a_rewind: assert property (p_rewind) // [RL10]
		else $error("rewind did not reach oldest entry");

	property p_code_advance;
		@(posedge core_clk) disable iff (!resetn)
		parReq && !parWr && !cmdReject && parAddr == `ADDR_ERROR_CODE
		&& !state_ff.clrPending && state_ff.rdPtr < hist.count
		|=> state_ff.rdPtr == $past(state_ff.rdPtr) + 4'h1
		&& parRdata == state_ff.hold.code;
	endproperty
	a_code_advance: assert property (p_code_advance) // [RL14]
		else $error("code read did not latch and advance");

	property p_empty_zero;
		@(posedge core_clk) disable iff (!resetn)
		parReq && !parWr && !cmdReject && parAddr == `ADDR_ERROR_CODE
		&& state_ff.rdPtr >= hist.count |=> parRdata == `WORD_ZERO;
	endproperty
	a_empty_zero: assert property (p_empty_zero) // [RL12]
		else $error("empty slot returned nonzero code");

	property p_reply_given;
		@(posedge core_clk) disable iff (!resetn)
		parReq |=> parAck;
	endproperty
	a_reply_given: assert property (p_reply_given) // [RL3]
		else $error("parameter request not answered");

	property p_ro_write_refused;
		@(posedge core_clk) disable iff (!resetn)
		parReq && parWr && parAddr != `ADDR_HISTORY_CLEAR
		&& parAddr != `ADDR_POINTER_REWIND
		|=> parErr && parRdata == `WORD_ZERO;
	endproperty
	a_ro_write_refused: assert property (p_ro_write_refused) // [RL3]
		else $error("write to read-only parameter accepted");

	// Sync flag must already show when the refusal is answered
	property p_sync_flag;
		@(posedge core_clk) disable iff (!resetn)
		parAck && parErr |-> commStatusWord[`CS_SYNC_BIT];
	endproperty
	a_sync_flag: assert property (p_sync_flag) // [RL3]
		else $error("refusal not shown in status word");

	property p_warn_no_stop;
		@(posedge core_clk) disable iff (!resetn)
		errEvent && !state_ff.errActive && errSeverity == SEV_WARN
		|=> $stable(lastStopCause) && $stable(opState);
	endproperty
	a_warn_no_stop: assert property (p_warn_no_stop) // [RL15]
		else $error("warning class changed the stop state");

	property p_fault_class;
		@(posedge core_clk) disable iff (!resetn)
		errEvent && !state_ff.errActive
		&& (errSeverity == SEV_FATAL_ACK || errSeverity == SEV_FATAL_LOCK)
		|=> opState == OP_FAULT && commStatusWord[`CS_FAULT_BIT];
	endproperty
	a_fault_class: assert property (p_fault_class) // [RL2]
		else $error("fatal class did not enter fault");

	property p_qstop_class;
		@(posedge core_clk) disable iff (!resetn)
		errEvent && !state_ff.errActive
		&& (errSeverity == SEV_QSTOP7 || errSeverity == SEV_QSTOP89)
		|=> opState == OP_QSTOP && commStatusWord[`CS_QSTOP_BIT];
	endproperty
	a_qstop_class: assert property (p_qstop_class) // [RL2]
		else $error("stop class did not enter quick stop");

	property p_ack_releases;
		@(posedge core_clk) disable iff (!resetn)
		errReset && state_ff.errActive
		&& state_ff.lastSev != SEV_FATAL_LOCK
		|=> opState == OP_RUN && lastStopCause == `WORD_ZERO;
	endproperty
	a_ack_releases: assert property (p_ack_releases) // [RL16]
		else $error("error reset did not release the stop");

	property p_clear_idle_zero;
		@(posedge core_clk) disable iff (!resetn)
		parReq && !parWr && !cmdReject && parAddr == `ADDR_HISTORY_CLEAR
		&& !state_ff.clrPending |=> parRdata == `WORD_ZERO;
	endproperty
	a_clear_idle_zero: assert property (p_clear_idle_zero) // [RL9]
		else $error("clear reported busy while idle");

	property p_time_from_hold;
		@(posedge core_clk) disable iff (!resetn)
		parReq && !parWr && !cmdReject && parAddr == `ADDR_ERROR_TIME_LO
		|=> parRdata == $past(state_ff.hold.errTime[15:0]);
	endproperty
	a_time_from_hold: assert property (p_time_from_hold) // [RL18]
		else $error("time word not taken from holding buffer");

	c_full_history: cover property (@(posedge core_clk)
		disable iff (!resetn) logEn && hist.count == 4'(`HIST_DEPTH));
	c_fault_stop: cover property (@(posedge core_clk)
		disable iff (!resetn) opState == OP_FAULT);
	c_clear_seen: cover property (@(posedge core_clk)
		disable iff (!resetn) clrEn);
endmodule
`default_nettype wire

// ### fieldbus_master.sv
`default_nettype none
module fieldbus_master (
	input wire logic core_clk,
	output logic parReq,
	output logic parWr,
	output logic [15:0] parAddr,
	output logic [15:0] parWdata,
	output logic cmdReject,
	input wire logic parAck,
	input wire logic parErr,
	input wire logic [15:0] parRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus never shows the last request
	initial begin
		parReq = 1'b0;
		parWr = 1'b0;
		parAddr = 16'hffff;
		parWdata = 16'hffff;
		cmdReject = 1'b0;
	end
	// One-cycle request pulse; answer awaited a bounded time
	task automatic access(input logic wr, input logic [15:0] a,
		input logic [15:0] d, input logic rej,
		output logic [15:0] rd, output logic er);
		rd = 16'hxxxx;
		er = 1'bx;
		@(negedge core_clk);
		parReq = 1'b1;
		parWr = wr;
		parAddr = a;
		parWdata = d;
		cmdReject = rej;
		@(negedge core_clk);
		parReq = 1'b0;
		parAddr = ~a;
		parWdata = ~d;
		cmdReject = 1'b0;
		// Missing answer leaves rd and er unknown
		for (int n = 0; n < 4; n++) begin
			if (parAck === 1'b1) begin
				rd = parRdata;
				er = parErr;
				break;
			end
			@(negedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

// ### drive_error_history_log_tb.sv
`default_nettype none
`include "drive_error_history_map.svh"
module drive_error_history_log_tb import drive_error_history_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic resetn, memInitn, parReq, parWr, cmdReject, parAck, parErr;
	logic [15:0] parAddr, parWdata, parRdata, errCode, errQual;
	logic [15:0] lastStopCause, commStatusWord, v;
	logic errEvent, errReset, runLed, e, prevLed;
	logic [31:0] opHours;
	severity_t errSeverity;
	net_state_t netState;
	op_state_t opState, expOp;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int cnt;
	always #25 core_clk = ~core_clk;
	fieldbus_master mst (.core_clk(core_clk), .parReq(parReq),
		.parWr(parWr), .parAddr(parAddr), .parWdata(parWdata),
		.cmdReject(cmdReject), .parAck(parAck), .parErr(parErr),
		.parRdata(parRdata));
	drive_error_history_log #(.FLASH_CYC(32'h0000_0004),
		.PAUSE_CYC(32'h0000_0010)) uut (.core_clk(core_clk),
		.resetn(resetn), .memInitn(memInitn), .parReq(parReq),
		.parWr(parWr), .parAddr(parAddr), .parWdata(parWdata),
		.cmdReject(cmdReject), .parAck(parAck), .parErr(parErr),
		.parRdata(parRdata), .errEvent(errEvent), .errCode(errCode),
		.errSeverity(errSeverity), .errQual(errQual),
		.opHours(opHours), .errReset(errReset), .netState(netState),
		.runLed(runLed), .opState(opState),
		.lastStopCause(lastStopCause),
		.commStatusWord(commStatusWord));
	task automatic report_and_stop;
		if (fail_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Hang guard, far above the expected run length
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			report_and_stop;
		end
	end
	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		num_checks++;
		if (g !== x) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", nm, x, g);
		end
	endtask
	task automatic rdchk(input string nm, input logic [15:0] a,
		input logic [15:0] x);
		mst.access(1'b0, a, 16'h0000, 1'b0, v, e);
		chk(nm, x, v);
		chk("rd err", 0, e);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		mst.access(1'b1, a, d, 1'b0, v, e);
		chk("wr err", 0, e);
	endtask
	// Entry fields derived from the code so each slot is distinct
	task automatic raise(input logic [15:0] c, input severity_t s);
		@(negedge core_clk);
		errEvent = 1'b1;
		errCode = c;
		errSeverity = s;
		errQual = ~c;
		opHours = {c, ~c};
		@(negedge core_clk);
		errEvent = 1'b0;
		errCode = ~c;
		@(negedge core_clk);
	endtask
	task automatic ack_errors;
		@(negedge core_clk);
		errReset = 1'b1;
		@(negedge core_clk);
		errReset = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic s_sync;
		mst.access(1'b0, 16'h3c00, 16'h0000, 1'b0, v, e);
		chk("unmapped", 32'h0001_0000, {e, v});
		mst.access(1'b1, `ADDR_HISTORY_CLEAR, 16'h0002, 1'b0, v, e);
		chk("range", 32'h0001_0000, {e, v});
		mst.access(1'b1, `ADDR_ERROR_CODE, 16'h0001, 1'b0, v, e);
		chk("ro wr", 32'h0001_0000, {e, v});
		mst.access(1'b0, `ADDR_LAST_STOP, 16'h0000, 1'b1, v, e);
		chk("reject", 32'h0001_0000, {e, v});
		chk("sync bit", 1, commStatusWord[`CS_SYNC_BIT]);
	endtask
	// Fault, dropped follow-on, then the latched entry fields
	task automatic s_entry;
		raise(16'h1234, SEV_FATAL_ACK);
		chk("stop", 16'h1234, lastStopCause);
		chk("op", OP_FAULT, opState);
		chk("fault bit", 1, commStatusWord[`CS_FAULT_BIT]);
		rdchk("status", `ADDR_COMM_STATUS, 16'h003b);
		raise(16'h5678, SEV_QSTOP7);
		rdchk("stop rd", `ADDR_LAST_STOP, 16'h1234);
		ack_errors;
		chk("stop clr", 0, lastStopCause);
		wr(`ADDR_POINTER_REWIND, 16'h0001);
		rdchk("code", `ADDR_ERROR_CODE, 16'h1234);
		rdchk("sev", `ADDR_ERROR_SEVERITY, 16'h0003);
		rdchk("t hi", `ADDR_ERROR_TIME_HI, 16'h1234);
		rdchk("t lo", `ADDR_ERROR_TIME_LO, 16'hedcb);
		rdchk("qual", `ADDR_ERROR_QUAL, 16'hedcb);
		rdchk("no 2nd", `ADDR_ERROR_CODE, 16'h0000);
	endtask
	// Class 4 survives acknowledge; warm reset keeps history
	task automatic s_fatal;
		raise(16'h4444, SEV_FATAL_LOCK);
		ack_errors;
		chk("locked", 16'h4444, lastStopCause);
		@(negedge core_clk);
		resetn = 1'b0;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		chk("warm", 0, lastStopCause);
		wr(`ADDR_POINTER_REWIND, 16'h0001);
		rdchk("kept 1", `ADDR_ERROR_CODE, 16'h1234);
		rdchk("kept 2", `ADDR_ERROR_CODE, 16'h4444);
		rdchk("sev 4", `ADDR_ERROR_SEVERITY, 16'h0004);
	endtask
	// Clear, then overfill by one and walk all ten slots
	task automatic s_fill;
		wr(`ADDR_HISTORY_CLEAR, 16'h0001);
		cnt = 0;
		do begin
			mst.access(1'b0, `ADDR_HISTORY_CLEAR, 16'h0, 1'b0, v, e);
			cnt++;
		end while (v !== 16'h0000 && cnt < 8);
		chk("clr done", 0, v);
		wr(`ADDR_POINTER_REWIND, 16'h0001);
		rdchk("cleared", `ADDR_ERROR_CODE, 16'h0000);
		for (int i = 0; i < 11; i++) begin
			raise(16'h0a00 + 16'(i), severity_t'(i % 4));
			expOp = (i % 4 == 3) ? OP_FAULT : OP_QSTOP;
			chk("op", (i % 4 == 0) ? OP_RUN : expOp, opState);
			ack_errors;
		end
		wr(`ADDR_POINTER_REWIND, 16'h0001);
		for (int k = 1; k < 11; k++) begin
			rdchk("slot", `ADDR_ERROR_CODE, 16'h0a00 + 16'(k));
			rdchk("slot sev", `ADDR_ERROR_SEVERITY, 16'(k % 4));
		end
		rdchk("past end", `ADDR_ERROR_CODE, 16'h0000);
	endtask
	// Flash counts per network state, pause 16, flash 4+4
	task automatic s_led;
		netState = NET_READY;
		repeat (2) @(negedge core_clk);
		chk("ready", 1, runLed);
		for (int n = 0; n < 7; n++) begin
			if (n == 1)
				continue;
			netState = net_state_t'(n);
			cnt = 0;
			prevLed = runLed;
			// Boot flashes with no pause: four rising edges in 48
			repeat ((n == 0) ? 48 : 24 + 8 * n) begin
				@(posedge core_clk);
				#1 cnt += (runLed === 1'b1 && prevLed === 1'b0);
				prevLed = runLed;
			end
			@(negedge core_clk);
			chk("flashes", (n == 0) ? 4 : n, cnt);
		end
	endtask
	initial begin
		resetn = 1'b0;
		memInitn = 1'b0;
		errEvent = 1'b0;
		errReset = 1'b0;
		errCode = 16'h0000;
		errQual = 16'h0000;
		errSeverity = SEV_WARN;
		opHours = 32'h0000_0000;
		netState = NET_BOOT;
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		memInitn = 1'b1;
		chk("rst stop", 0, lastStopCause);
		chk("rst op", OP_RUN, opState);
		wr(`ADDR_POINTER_REWIND, 16'h0001);
		rdchk("empty", `ADDR_ERROR_CODE, 16'h0000);
		s_sync;
		s_entry;
		s_fatal;
		s_fill;
		s_led;
		report_and_stop;
	end
endmodule
`default_nettype wire
